// [fifo_channel.sv]
// Purpose: one channel of a dual-clock 9-bit FIFO with programmable flags
// Assumes: write and read clocks are pins sampled by core_clk, well below its rate
// Notes: all pins pass two flip-flops together, so data stays aligned to its clock edge
`timescale 1ns/1ps
`include "fifo_channel_consts.svh"

// Overview of operation
// - Nine-bit write and read words, separate buses
// - Channel reset returns both pointers to zero
// - Reset sets flags, zeroes output, restores offsets
// - Writes and full flags follow write clock
// - Write and read clocks independent or shared
// - Programmable mode: primary enable alone gates writes
// - Full channel drives full low, ignores writes
// - A read from full releases full flag
// - Both read enables low loads next word
// - Either read enable high holds output
// - Empty channel drives empty low, ignores reads
// - Write into empty channel raises empty flag
// - Empty flags follow the read clock
// - Output enable low drives bus, high floats
// - Second enable sampled at reset picks mode
// - Two-enable mode: primary low, second high writes
// - Four eight-bit offset registers, load and readback
// - Load sequence empty low/high, full low/high, wrap
// - Partial load resumes at next offset register
// - Offset readback uses the same sequence
// - Both offsets default to seven
// - Full flag low at depth words stored
// - Almost-full low at depth minus full offset
// - Almost-empty low up to empty offset words
module fifo_channel
  import fifo_channel_pkg::*;
#(
  parameter int DEPTH = `DEPTH_DEFAULT
) (
  input wire logic core_clk, // System clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic [`WORD_W-1:0] write_word_in, // Write data pins
  input wire logic write_clock, // Write clock pin
  input wire logic read_clock, // Read clock pin
  input wire logic primary_write_enable_n, // Primary write enable
  input wire logic second_enable_or_load, // Second enable or load
  input wire logic first_read_enable_n, // First read enable
  input wire logic second_read_enable_n, // Second read enable
  input wire logic output_drive_enable_n, // Output enable pin
  input wire logic second_channel_reset_n, // Channel reset pin
  output logic [`WORD_W-1:0] read_word_out, // Output register
  output logic read_word_oe, // High while the bus is driven
  output logic full_flag_n, // Full, active low
  output logic empty_flag_n, // Empty, active low
  output logic almost_full_flag_n, // Almost full, active low
  output logic almost_empty_flag_n // Almost empty, active low
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = AW + 1;
  localparam int XW = 17;
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  localparam logic [CW-1:0] DEPTH_CNT = CW'(DEPTH);
  localparam logic [XW-1:0] DEPTH_X = XW'(DEPTH);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and clock edge detection

  pin_bundle_t pins_raw;
  pin_bundle_t sync1_q;
  pin_bundle_t sync2_q;
  pin_bundle_t prev_q;

  // Sync flops reset to each pin's idle level, so no false edge or drive follows
  // reset; the channel reset pin reads active, holding the channel in reset, and load low reads active in programmable mode.
  localparam pin_bundle_t PINS_IDLE = '{
    wclk: 1'b0,
    rclk: 1'b0,
    wen1_n: 1'b1,
    we2_ld: 1'b0,
    ren1_n: 1'b1,
    ren2_n: 1'b1,
    oe_n: 1'b1,
    rst_n: 1'b0,
    din: '0
  };

  assign pins_raw = '{
    wclk: write_clock,
    rclk: read_clock,
    wen1_n: primary_write_enable_n,
    we2_ld: second_enable_or_load,
    ren1_n: first_read_enable_n,
    ren2_n: second_read_enable_n,
    oe_n: output_drive_enable_n,
    rst_n: second_channel_reset_n,
    din: write_word_in
  };

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= PINS_IDLE;
      sync2_q <= PINS_IDLE;
      prev_q <= PINS_IDLE;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Each pin clock is just a sampled level; its rise becomes a one-cycle enable.
  // Shared or unrelated clocks both work, since each side only sees its own edge.
  wire wr_edge = sync2_q.wclk & ~prev_q.wclk;
  wire rd_edge = sync2_q.rclk & ~prev_q.rclk;
  wire chan_rst = ~sync2_q.rst_n;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration and request decode

  chan_mode_t mode_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= MODE_PROG;
    end else if (chan_rst) begin
      mode_q <= sync2_q.we2_ld ? MODE_TWO_WE : MODE_PROG;
    end
  end

  logic full_q;
  logic empty_q;
  logic afull_q;
  logic aempty_q;

  wire prog_mode = (mode_q == MODE_PROG);
  wire load_active = prog_mode & ~sync2_q.we2_ld;
  wire write_en = prog_mode ? ~sync2_q.wen1_n
                            : (~sync2_q.wen1_n & sync2_q.we2_ld);
  wire read_en = ~sync2_q.ren1_n & ~sync2_q.ren2_n;

  // Full and empty gate on the flags: the count can only move toward
  // safety between edges of the flag's own side, so the flags never lie.
  wire fifo_wr = wr_edge & ~chan_rst & ~load_active & write_en & full_q;
  wire fifo_rd = rd_edge & ~chan_rst & ~load_active & read_en & empty_q;
  wire ofs_wr = wr_edge & ~chan_rst & load_active & ~sync2_q.wen1_n;
  wire ofs_rd = rd_edge & ~chan_rst & load_active & read_en;

  //////////////////////////////////////////////////////////////////////////////
  // Offset registers

  logic [`OFS_W-1:0] ofs_q [`OFS_COUNT];
  logic [`OFS_SEL_W-1:0] ofs_wr_sel_q;
  logic [`OFS_SEL_W-1:0] ofs_rd_sel_q;

  // Each entry resets to its default and loads from the low data bits.
  for (genvar i = 0; i < `OFS_COUNT; i++) begin : g_ofs
    localparam logic [`OFS_SEL_W-1:0] IDX = `OFS_SEL_W'(i);
    localparam logic [`OFS_W-1:0] RST_VAL =
      (IDX == `OFS_EMPTY_LOW || IDX == `OFS_FULL_LOW) ? `OFS_LOW_RESET
                                                      : `OFS_HIGH_RESET;
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        ofs_q[i] <= RST_VAL;
      end else if (chan_rst) begin
        ofs_q[i] <= RST_VAL;
      end else if (ofs_wr && ofs_wr_sel_q == IDX) begin
        ofs_q[i] <= sync2_q.din[`OFS_W-1:0];
      end
    end
  end

  // Selectors keep their place when load goes high, so a later load resumes.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ofs_wr_sel_q <= `OFS_EMPTY_LOW;
      ofs_rd_sel_q <= `OFS_EMPTY_LOW;
    end else if (chan_rst) begin
      ofs_wr_sel_q <= `OFS_EMPTY_LOW;
      ofs_rd_sel_q <= `OFS_EMPTY_LOW;
    end else begin
      if (ofs_wr) begin
        ofs_wr_sel_q <= ofs_wr_sel_q + 2'h1;
      end
      if (ofs_rd) begin
        ofs_rd_sel_q <= ofs_rd_sel_q + 2'h1;
      end
    end
  end

  wire [15:0] empty_ofs = {ofs_q[`OFS_EMPTY_HIGH], ofs_q[`OFS_EMPTY_LOW]};
  wire [15:0] full_ofs = {ofs_q[`OFS_FULL_HIGH], ofs_q[`OFS_FULL_LOW]};

  //////////////////////////////////////////////////////////////////////////////
  // Storage, pointers and word count

  logic [`WORD_W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [CW-1:0] count_q;

  wire [AW-1:0] wptr_inc = (wptr_q == LAST_PTR) ? '0 : wptr_q + AW'(1);
  wire [AW-1:0] rptr_inc = (rptr_q == LAST_PTR) ? '0 : rptr_q + AW'(1);
  wire [CW-1:0] count_d = count_q + CW'(fifo_wr) - CW'(fifo_rd);

  // Storage has no reset; stale words are never visible past the pointers.
  always_ff @(posedge core_clk) begin
    if (fifo_wr) begin
      mem_q[wptr_q] <= sync2_q.din;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end else if (chan_rst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end else begin
      if (fifo_wr) begin
        wptr_q <= wptr_inc;
      end
      if (fifo_rd) begin
        rptr_q <= rptr_inc;
      end
      count_q <= count_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flags: write-side flags move on write edges, read-side on read edges

  wire [XW-1:0] count_x = XW'(count_d);
  wire full_now = (count_d == DEPTH_CNT);
  wire afull_now = (count_x + XW'(full_ofs)) >= DEPTH_X;
  wire empty_now = (count_d == '0);
  wire aempty_now = count_x <= XW'(empty_ofs);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      full_q <= 1'b1;
      afull_q <= 1'b1;
    end else if (chan_rst) begin
      full_q <= 1'b1;
      afull_q <= 1'b1;
    end else if (wr_edge) begin
      full_q <= ~full_now;
      afull_q <= ~afull_now;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      empty_q <= 1'b0;
      aempty_q <= 1'b0;
    end else if (chan_rst) begin
      empty_q <= 1'b0;
      aempty_q <= 1'b0;
    end else if (rd_edge) begin
      empty_q <= ~empty_now;
      aempty_q <= ~aempty_now;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output register and bus drive

  logic [`WORD_W-1:0] out_q;
  logic oe_q;

  wire [`WORD_W-1:0] ofs_word = {1'b0, ofs_q[ofs_rd_sel_q]};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_q <= `OUT_RESET;
    end else if (chan_rst) begin
      out_q <= `OUT_RESET;
    end else if (fifo_rd) begin
      out_q <= mem_q[rptr_q];
    end else if (ofs_rd) begin
      out_q <= ofs_word;
    end
  end

  // The pad itself floats the bus; this only tells it when to drive.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ~sync2_q.oe_n;
    end
  end

  assign read_word_out = out_q;
  assign read_word_oe = oe_q;
  assign full_flag_n = full_q;
  assign empty_flag_n = empty_q;
  assign almost_full_flag_n = afull_q;
  assign almost_empty_flag_n = aempty_q;

endmodule

// [fifo_channel_chk.sv]
// Purpose: port checks for one FIFO channel
// Assumes: pin levels last at least three core cycles
// Notes: windows allow for the two-flop pin synchroniser
`timescale 1ns/1ps
`include "fifo_channel_consts.svh"
module fifo_channel_chk #(
  parameter int DEPTH = `DEPTH_DEFAULT
) (
  input wire logic core_clk, // Clock
  input wire logic nrst, // Reset
  input wire logic [`WORD_W-1:0] write_word_in, // Data
  input wire logic write_clock, // Wclk
  input wire logic read_clock, // Rclk
  input wire logic primary_write_enable_n, // We1
  input wire logic second_enable_or_load, // We2
  input wire logic first_read_enable_n, // Re1
  input wire logic second_read_enable_n, // Re2
  input wire logic output_drive_enable_n, // Oe
  input wire logic second_channel_reset_n, // Chrst
  input wire logic [`WORD_W-1:0] read_word_out, // Out
  input wire logic read_word_oe, // Drive
  input wire logic full_flag_n, // Full
  input wire logic empty_flag_n, // Empty
  input wire logic almost_full_flag_n, // Afull
  input wire logic almost_empty_flag_n // Aempty
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Pin history is meaningless until the synchroniser has refilled
  logic [2:0] up_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) up_q <= 3'h0;
    else if (up_q != 3'h4) up_q <= up_q + 3'h1;
  end
  ////////////////////////////////////////
  sequence ch_held; !second_channel_reset_n [*4]; endsequence
  sequence wr_idle; (!write_clock && second_channel_reset_n) [*6]; endsequence
  sequence rd_idle; (!read_clock && second_channel_reset_n) [*6]; endsequence
  sequence rd_off; ((first_read_enable_n || second_read_enable_n) && second_channel_reset_n) [*8];
  endsequence
  sequence run6; second_channel_reset_n [*6]; endsequence
  AST_CHAN_RESET: assert property (ch_held |=> full_flag_n && almost_full_flag_n
    && !empty_flag_n && !almost_empty_flag_n && read_word_out == 9'h000)
    else $error("channel reset left flags or output wrong");
  AST_WR_SYNC: assert property (wr_idle |-> $stable(full_flag_n)
    && $stable(almost_full_flag_n)) else $error("full flags moved without write clock");
  AST_RD_SYNC: assert property (rd_idle |-> $stable(empty_flag_n)
    && $stable(almost_empty_flag_n) && $stable(read_word_out))
    else $error("read side moved without read clock");
  AST_RD_HOLD: assert property (rd_off |-> $stable(read_word_out))
    else $error("output changed with a read enable high");
  AST_RD_CAUSE: assert property (run6 ##0 $changed(read_word_out) |->
    !$past(first_read_enable_n, 3) && !$past(second_read_enable_n, 3) && $past(read_clock, 3))
    else $error("output changed without an enabled read");
  AST_OE_FOLLOWS: assert property (up_q == 3'h4 |->
    read_word_oe == !$past(output_drive_enable_n, 3)) else $error("drive enable wrong");
  AST_FULL_AFULL: assert property (!full_flag_n |-> !almost_full_flag_n)
    else $error("full without almost full");
  AST_EMPTY_AEMPTY: assert property (!empty_flag_n |-> !almost_empty_flag_n)
    else $error("empty without almost empty");
endmodule
bind fifo_channel fifo_channel_chk #(.DEPTH(DEPTH)) u_chk (
  .core_clk(core_clk), .nrst(nrst), .write_word_in(write_word_in),
  .write_clock(write_clock), .read_clock(read_clock),
  .primary_write_enable_n(primary_write_enable_n), .second_enable_or_load(second_enable_or_load),
  .first_read_enable_n(first_read_enable_n), .second_read_enable_n(second_read_enable_n),
  .output_drive_enable_n(output_drive_enable_n), .second_channel_reset_n(second_channel_reset_n),
  .read_word_out(read_word_out), .read_word_oe(read_word_oe), .full_flag_n(full_flag_n),
  .empty_flag_n(empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
  .almost_empty_flag_n(almost_empty_flag_n));

// [fifo_channel_consts.svh]
// Purpose: timing, reset and field constants for one FIFO channel
// Assumes: included by its bare name from the package and the channel module
// Notes: offset register indices follow the load and read-back order
`ifndef FIFO_CHANNEL_CONSTS_SVH
`define FIFO_CHANNEL_CONSTS_SVH

// Word and offset widths
`define WORD_W 9
`define OFS_W 8
`define OFS_COUNT 4
`define OFS_SEL_W 2

// Default channel depth in words
`define DEPTH_DEFAULT 256

// Core clock period in ns (25 MHz)
`define CORE_CLK_NS 40

// Offset register indices, in load order
`define OFS_EMPTY_LOW 2'h0
`define OFS_EMPTY_HIGH 2'h1
`define OFS_FULL_LOW 2'h2
`define OFS_FULL_HIGH 2'h3

// Offset reset values: each offset defaults to seven
`define OFS_LOW_RESET 8'h07
`define OFS_HIGH_RESET 8'h00

// Output register reset value
`define OUT_RESET 9'h000

`endif

// [fifo_channel_pkg.sv]
// Purpose: types shared by the FIFO channel
// Assumes: constants come from fifo_channel_consts.svh
// Notes: the pin bundle is synchronised as one unit
`include "fifo_channel_consts.svh"

package fifo_channel_pkg;

  // Configuration chosen while the channel is held in reset
  typedef enum logic {
    MODE_PROG,
    MODE_TWO_WE
  } chan_mode_t;

  // All pins that arrive from outside the core clock domain
  typedef struct packed {
    logic wclk;
    logic rclk;
    logic wen1_n;
    logic we2_ld;
    logic ren1_n;
    logic ren2_n;
    logic oe_n;
    logic rst_n;
    logic [`WORD_W-1:0] din;
  } pin_bundle_t;

endpackage

// [fifo_channel_tb.sv]
// Purpose: self-checking bench for one FIFO channel
// Assumes: a queue model of the channel predicts every result
// Notes: small depth keeps full and almost-full reachable
`timescale 1ns/1ps
`include "fifo_channel_consts.svh"
module fifo_channel_tb;
  import fifo_channel_pkg::*;
  localparam int DEPTH = 16;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic ch_n = 1'b1;
  logic oe_n = 1'b1;
  logic [8:0] din, dout, mo;
  logic wclk, rclk, we1, we2, re1, re2, oe, f_n, e_n, af_n, ae_n, ff, ef, two_we;
  logic [8:0] q[$];
  int offs[4];
  int lsel, rsel, n_errors, checks_done, cycles;
  fifo_channel #(.DEPTH(DEPTH)) dut (.core_clk(core_clk), .nrst(nrst), .write_word_in(din),
    .write_clock(wclk), .read_clock(rclk), .primary_write_enable_n(we1),
    .second_enable_or_load(we2), .first_read_enable_n(re1), .second_read_enable_n(re2),
    .output_drive_enable_n(oe_n), .second_channel_reset_n(ch_n), .read_word_out(dout),
    .read_word_oe(oe), .full_flag_n(f_n), .empty_flag_n(e_n), .almost_full_flag_n(af_n),
    .almost_empty_flag_n(ae_n));
  fifo_peer u_peer (.core_clk(core_clk), .write_word_in(din), .write_clock(wclk),
    .read_clock(rclk), .primary_write_enable_n(we1), .second_enable_or_load(we2),
    .first_read_enable_n(re1), .second_read_enable_n(re2));
  initial forever #(`CORE_CLK_NS / 2) core_clk = ~core_clk;
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Flags go stale between own-side clocks, so acceptance uses the last refreshed flag
  task automatic wr(input logic [8:0] d, input logic w1, input logic w2);
    int fo;
    // Almost-full is judged against the full offset in force before this edge
    fo = offs[3] * 256 + offs[2];
    u_peer.push(d, w1, w2);
    if (!two_we && !w2) begin
      if (!w1) offs[lsel] = d[7:0];
      if (!w1) lsel = (lsel + 1) % 4;
    end else if (!w1 && w2 && ff) q.push_back(d);
    ff = q.size() != DEPTH;
    chk(f_n, ff);
    chk(af_n, q.size() < DEPTH - fo);
  endtask
  task automatic rd(input logic r1, input logic r2);
    u_peer.pull(r1, r2);
    if (!two_we && !we2 && !r1 && !r2) begin
      mo = 9'(offs[rsel]);
      rsel = (rsel + 1) % 4;
    end else if (!r1 && !r2 && ef) mo = q.pop_front();
    ef = q.size() != 0;
    chk(dout, mo);
    chk(e_n, ef);
    chk(ae_n, q.size() > offs[1] * 256 + offs[0]);
  endtask
  task automatic chrst(input logic m);
    ch_n = 1'b0;
    u_peer.push(9'h000, 1'b1, m);
    q.delete();
    offs = '{`OFS_LOW_RESET, `OFS_HIGH_RESET, `OFS_LOW_RESET, `OFS_HIGH_RESET};
    lsel = 0;
    rsel = 0;
    two_we = m;
    ff = 1'b1;
    ef = 1'b0;
    mo = `OUT_RESET;
    chk({f_n, af_n, e_n, ae_n}, 9'h00c);
    chk(dout, 9'h000);
    ch_n = 1'b1;
    u_peer.cyc(3);
  endtask
  task automatic traffic(input int n);
    repeat (n) wr(9'($urandom), $urandom % 4 == 0, two_we ? $urandom % 4 != 0 : 1'b1);
    repeat (n) rd($urandom % 4 == 0, $urandom % 4 == 0);
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h513a0efc));
    repeat (8) @(posedge core_clk);
    #1 nrst = 1'b1;
    chrst(1'b0);
    traffic(2 * DEPTH);
    traffic(2);
    wr(9'h000, 1'b1, 1'b0);
    repeat (4) rd(1'b0, 1'b0);
    for (int i = 0; i < 6; i++) wr(lsel[0] ? 9'h000 : 9'(1 + $urandom % 8), i == 2, 1'b0);
    repeat (5) rd(1'b0, 1'b0);
    rd(1'b1, 1'b0);
    traffic(2 * DEPTH);
    wr(9'h1a5, 1'b0, 1'b0);
    rd(1'b0, 1'b0);
    chrst(1'b1);
    traffic(DEPTH);
    oe_n = 1'b0;
    u_peer.cyc(4);
    chk(oe, 1'b1);
    oe_n = 1'b1;
    u_peer.cyc(4);
    chk(oe, 1'b0);
    give_verdict();
  end
endmodule

// [fifo_peer.sv]
// Purpose: producer and consumer driving the channel pins
// Assumes: each clock level lasts at least three core cycles
// Notes: clocks stand low between transfers
`timescale 1ns/1ps
`include "fifo_channel_consts.svh"
module fifo_peer (
  input wire logic core_clk, // Clock
  output logic [`WORD_W-1:0] write_word_in, // Data
  output logic write_clock, // Wclk
  output logic read_clock, // Rclk
  output logic primary_write_enable_n, // We1
  output logic second_enable_or_load, // We2
  output logic first_read_enable_n, // Re1
  output logic second_read_enable_n // Re2
);
  initial begin
    {write_word_in, write_clock, read_clock} = '0;
    {primary_write_enable_n, second_enable_or_load} = 2'h3;
    {first_read_enable_n, second_read_enable_n} = 2'h3;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // One transfer at a time, so offsets are never read and written together
  task automatic push(input logic [8:0] d, input logic w1, input logic w2);
    write_word_in = d;
    primary_write_enable_n = w1;
    second_enable_or_load = w2;
    cyc(1);
    write_clock = 1'b1;
    cyc(4);
    write_clock = 1'b0;
    write_word_in = ~d;
    cyc(3);
  endtask
  task automatic pull(input logic r1, input logic r2);
    first_read_enable_n = r1;
    second_read_enable_n = r2;
    cyc(1);
    read_clock = 1'b1;
    cyc(4);
    read_clock = 1'b0;
    cyc(3);
  endtask
endmodule
